// *** cfa_pkg.sv ***
// cfa_pkg: register indices, mode codes, reset values and sizes
// assumes one 25 MHz clock domain and a 16-bit sample stream
package cfa_pkg;
   // register indices as presented on the register port
   localparam logic [15:0] IDX_MODE = 16'h251C;
   localparam logic [15:0] IDX_SEGLEN = 16'h271A;
   localparam logic [15:0] IDX_LOOPS = 16'h2724;
   localparam logic [15:0] IDX_PRE = 16'h2800;
   // operating mode codes
   localparam logic [31:0] MODE_STREAM = 32'h0000_0010;
   localparam logic [31:0] MODE_MEMONLY = 32'h0000_0001;
   // reset values
   localparam logic [31:0] RST_MODE = 32'h0000_0001;
   localparam logic [63:0] RST_SEGLEN = 64'h0000_0000_0000_0400;
   localparam logic [63:0] RST_LOOPS = 64'h0000_0000_0000_0000;
   localparam logic [63:0] RST_PRE = 64'h0000_0000_0000_0000;
   // sample and memory organisation
   localparam int SAMPLE_W = 16;
   localparam int SAMPLE_BYTES = 2;
   localparam int MEM_AW = 10;
   localparam logic [MEM_AW:0] MEM_DEPTH = 11'h400;
   localparam int PRE_AW = 4;
   localparam logic [PRE_AW:0] PRE_MAX = 5'h0F;
   typedef enum logic [2:0] {ST_IDLE, ST_FILL, ST_ARMED, ST_RUN, ST_DONE}
      cfa_state_e;
endpackage

// *** cfa_strm_if.sv ***
// cfa_strm_if: valid/ready sample stream between acquisition blocks
// assumes both ends sit on clk_sys
`timescale 1ns/10ps
interface cfa_strm_if;
   logic valid;
   logic ready;
   logic [cfa_pkg::SAMPLE_W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// *** cfa_pre_fifo.sv ***
// cfa_pre_fifo: small circular store for pre-event samples
// assumes the caller never pushes when full without popping too
`timescale 1ns/10ps
module cfa_pre_fifo (
   input wire logic clk_sys, // system clock
   input wire logic srst, // synchronous reset
   input wire logic clr, // drop all contents
   input wire logic push, // write din at tail
   input wire logic pop, // remove head
   input wire logic [cfa_pkg::SAMPLE_W-1:0] din, // sample in
   output logic [cfa_pkg::SAMPLE_W-1:0] dout, // head sample
   output logic [cfa_pkg::PRE_AW:0] count // samples held
);
   logic [cfa_pkg::SAMPLE_W-1:0] mem [0:(1<<cfa_pkg::PRE_AW)-1];
   logic [cfa_pkg::PRE_AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [cfa_pkg::PRE_AW:0] cnt_r, cnt_nxt;

   // pointer and fill bookkeeping
   always_comb
   begin
      wp_nxt = wp_r + {{(cfa_pkg::PRE_AW-1){1'b0}}, push};
      rp_nxt = rp_r + {{(cfa_pkg::PRE_AW-1){1'b0}}, pop};
      cnt_nxt = cnt_r + {{cfa_pkg::PRE_AW{1'b0}}, push}
                - {{cfa_pkg::PRE_AW{1'b0}}, pop};
      if (clr)
      begin
         wp_nxt = '0;
         rp_nxt = '0;
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // sample storage, no reset needed
   always_ff @(posedge clk_sys)
   begin
      if (push && !clr)
         mem[wp_r] <= din;
   end

   assign dout = mem[rp_r];
   assign count = cnt_r;
endmodule

// *** cfa_skid2.sv ***
// cfa_skid2: two-entry buffer between sample memory and host transfer
// assumes the host side may hold o_ready low for any time
`timescale 1ns/10ps
module cfa_skid2 (
   input wire logic clk_sys, // system clock
   input wire logic srst, // synchronous reset
   cfa_strm_if.snk in_s, // words from sample memory
   output logic o_valid, // word available to host
   input wire logic o_ready, // host takes word
   output logic [cfa_pkg::SAMPLE_W-1:0] o_data // word to host
);
   logic [cfa_pkg::SAMPLE_W-1:0] d0_r, d0_nxt, d1_r, d1_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic take, give;

   // entry shift and fill count
   always_comb
   begin
      take = in_s.valid && (cnt_r != 2'h2);
      give = (cnt_r != 2'h0) && o_ready;
      d0_nxt = d0_r;
      d1_nxt = d1_r;
      cnt_nxt = cnt_r;
      if (give)
      begin
         d0_nxt = d1_r;
         cnt_nxt = cnt_nxt - 2'h1;
      end
      if (take)
      begin
         if (cnt_nxt == 2'h0)
            d0_nxt = in_s.data;
         else
            d1_nxt = in_s.data;
         cnt_nxt = cnt_nxt + 2'h1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         d0_r <= '0;
         d1_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         d0_r <= d0_nxt;
         d1_r <= d1_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign in_s.ready = (cnt_r != 2'h2);
   assign o_valid = (cnt_r != 2'h0);
   assign o_data = d0_r;

   // a stalled word stays put until taken
   AST_SKID_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
      o_valid && !o_ready |=> o_valid && $stable(o_data))
      else $error("stalled output word changed");
endmodule

// *** cfa_stream_acq.sv ***
// cfa_stream_acq: streaming acquisition sequencer with sample memory fifo
// assumes samples and trigger are synchronous to clk_sys and the host
// transfer engine drains dma_data under valid/ready
// Behaviour
// - mode code 10h selects continuous streaming
// - mode selector read back returns active mode
// - samples drain to host during acquisition
// - programmable count of samples before trigger
// - pre-event samples held in small fifo
// - segment length register sets samples per segment
// - repeat count register sets total segments
// - zero repeat streams until stop command
// - nonzero repeat acquires count times length
// - each sample takes two bytes of memory
// - memory limit follows channels and installed memory
// - pre-event limits are fixed constants
// - overflow flag when memory fifo overflows
// - trigger disarmed until pre-event area full
`timescale 1ns/10ps
module cfa_stream_acq (
   input wire logic clk_sys, // system clock, 25 MHz
   input wire logic srst, // synchronous reset, active high
   input wire logic [15:0] reg_addr, // register index
   input wire logic reg_wr, // register write strobe
   input wire logic [63:0] reg_wdata, // register write data
   output logic [63:0] reg_rdata, // register read data
   input wire logic cmd_start, // start acquisition pulse
   input wire logic cmd_stop, // stop acquisition pulse
   input wire logic trig_in, // trigger event
   input wire logic [1:0] chan_sel, // 0: 1, 1: 2, 2: 4 channels
   input wire logic adc_valid, // converter sample strobe
   input wire logic [15:0] adc_data, // converter sample
   output logic dma_valid, // word for host memory
   input wire logic dma_ready, // host transfer takes word
   output logic [15:0] dma_data, // word for host memory
   output logic acq_running, // acquisition in progress
   output logic trig_armed, // trigger accepted now
   output logic acq_done, // configured segments captured
   output logic stream_overflow_flag, // memory fifo overflowed
   output logic [11:0] mem_fill_bytes // bytes held in memory fifo
);
   localparam int AW = cfa_pkg::MEM_AW;

   cfa_strm_if buf_s ();

   logic [31:0] mode_r, mode_nxt;
   logic [63:0] seglen_r, seglen_nxt, loops_r, loops_nxt, pre_r, pre_nxt;
   logic [63:0] rdata_r, rdata_nxt;
   cfa_pkg::cfa_state_e st_r, st_nxt;
   logic [63:0] smp_r, smp_nxt, seg_r, seg_nxt;
   logic ovf_r, ovf_nxt, done_r, done_nxt;
   logic [15:0] mem [0:(1<<AW)-1];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] mcnt_r, mcnt_nxt, mem_limit;
   logic [cfa_pkg::PRE_AW:0] pre_eff, pre_cnt;
   logic [15:0] pre_dout, mem_wd;
   logic pre_push, pre_pop, pre_clr, mem_we, mem_re, fwd, room;

   // register file: writes and registered read-back
   always_comb
   begin
      mode_nxt = mode_r;
      seglen_nxt = seglen_r;
      loops_nxt = loops_r;
      pre_nxt = pre_r;
      if (reg_wr)
      begin
         case (reg_addr)
            cfa_pkg::IDX_MODE: mode_nxt = reg_wdata[31:0];
            cfa_pkg::IDX_SEGLEN: seglen_nxt = reg_wdata;
            cfa_pkg::IDX_LOOPS: loops_nxt = reg_wdata;
            cfa_pkg::IDX_PRE: pre_nxt = reg_wdata;
            default: mode_nxt = mode_r;
         endcase
      end
      case (reg_addr)
         cfa_pkg::IDX_MODE: rdata_nxt = {32'h0000_0000, mode_r};
         cfa_pkg::IDX_SEGLEN: rdata_nxt = seglen_r;
         cfa_pkg::IDX_LOOPS: rdata_nxt = loops_r;
         cfa_pkg::IDX_PRE: rdata_nxt = pre_r;
         default: rdata_nxt = 64'h0000_0000_0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         mode_r <= cfa_pkg::RST_MODE;
         seglen_r <= cfa_pkg::RST_SEGLEN;
         loops_r <= cfa_pkg::RST_LOOPS;
         pre_r <= cfa_pkg::RST_PRE;
         rdata_r <= '0;
      end
      else
      begin
         mode_r <= mode_nxt;
         seglen_r <= seglen_nxt;
         loops_r <= loops_nxt;
         pre_r <= pre_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // fixed pre-event ceiling, independent of channels and memory
   assign pre_eff = (pre_r > {59'h0, cfa_pkg::PRE_MAX}) ? cfa_pkg::PRE_MAX
                    : pre_r[cfa_pkg::PRE_AW:0];
   // usable memory scales with installed depth, inversely with channel count
   assign mem_limit = cfa_pkg::MEM_DEPTH >> chan_sel;
   assign room = (mcnt_r < mem_limit);

   // sequencer: fill, arm, stream segments, finish
   always_comb
   begin
      st_nxt = st_r;
      smp_nxt = smp_r;
      seg_nxt = seg_r;
      ovf_nxt = ovf_r;
      done_nxt = done_r;
      pre_push = 1'b0;
      pre_pop = 1'b0;
      pre_clr = 1'b0;
      fwd = 1'b0;
      mem_we = 1'b0;
      mem_wd = adc_data;
      case (st_r)
         cfa_pkg::ST_IDLE, cfa_pkg::ST_DONE:
         begin
            if (cmd_start && mode_r == cfa_pkg::MODE_STREAM)
            begin
               st_nxt = cfa_pkg::ST_FILL;
               smp_nxt = '0;
               seg_nxt = '0;
               ovf_nxt = 1'b0;
               done_nxt = 1'b0;
               pre_clr = 1'b1;
            end
         end
         cfa_pkg::ST_FILL:
         begin
            // trigger ignored until full; once full the window slides
            pre_push = adc_valid && (pre_eff != '0);
            pre_pop = pre_push && (pre_cnt >= pre_eff);
            if (pre_cnt >= pre_eff)
               st_nxt = cfa_pkg::ST_ARMED;
         end
         cfa_pkg::ST_ARMED:
         begin
            if (trig_in)
            begin
               // trigger sample joins the pre-event samples
               pre_push = adc_valid;
               st_nxt = cfa_pkg::ST_RUN;
            end
            else if (pre_eff != '0)
            begin
               pre_push = adc_valid;
               pre_pop = adc_valid && (pre_cnt >= pre_eff);
            end
         end
         cfa_pkg::ST_RUN:
         begin
            // older pre-event samples leave first, live ones queue
            if (pre_cnt != '0)
            begin
               fwd = 1'b1;
               pre_pop = 1'b1;
               pre_push = adc_valid;
               mem_wd = pre_dout;
            end
            else
               fwd = adc_valid;
            if (fwd)
            begin
               if (room)
                  mem_we = 1'b1;
               else
                  ovf_nxt = 1'b1;
               smp_nxt = smp_r + 64'h1;
               if (smp_nxt == seglen_r)
               begin
                  smp_nxt = '0;
                  seg_nxt = seg_r + 64'h1;
                  if (loops_r != '0 && seg_nxt == loops_r)
                  begin
                     st_nxt = cfa_pkg::ST_DONE;
                     done_nxt = 1'b1;
                  end
               end
            end
         end
         default: st_nxt = cfa_pkg::ST_IDLE;
      endcase
      // endless capture only ends here
      if (cmd_stop && st_r != cfa_pkg::ST_IDLE
          && st_r != cfa_pkg::ST_DONE)
         st_nxt = cfa_pkg::ST_IDLE;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st_r <= cfa_pkg::ST_IDLE;
         smp_r <= '0;
         seg_r <= '0;
         ovf_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         smp_r <= smp_nxt;
         seg_r <= seg_nxt;
         ovf_r <= ovf_nxt;
         done_r <= done_nxt;
      end
   end

   cfa_pre_fifo u_pre (
      .clk_sys (clk_sys),
      .srst (srst),
      .clr (pre_clr),
      .push (pre_push),
      .pop (pre_pop),
      .din (adc_data),
      .dout (pre_dout),
      .count (pre_cnt)
   );

   // sample memory used as one fifo toward the host
   always_comb
   begin
      mem_re = (mcnt_r != '0) && buf_s.ready;
      wp_nxt = wp_r + {{(AW-1){1'b0}}, mem_we};
      rp_nxt = rp_r + {{(AW-1){1'b0}}, mem_re};
      mcnt_nxt = mcnt_r + {{AW{1'b0}}, mem_we} - {{AW{1'b0}}, mem_re};
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         wp_r <= '0;
         rp_r <= '0;
         mcnt_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         mcnt_r <= mcnt_nxt;
      end
   end

   // storage array, no reset needed
   always_ff @(posedge clk_sys)
   begin
      if (mem_we)
         mem[wp_r] <= mem_wd;
   end

   assign buf_s.valid = (mcnt_r != '0);
   assign buf_s.data = mem[rp_r];

   cfa_skid2 u_buf (
      .clk_sys (clk_sys),
      .srst (srst),
      .in_s (buf_s),
      .o_valid (dma_valid),
      .o_ready (dma_ready),
      .o_data (dma_data)
   );

   // status outputs
   assign reg_rdata = rdata_r;
   assign acq_running = (st_r == cfa_pkg::ST_FILL)
                        || (st_r == cfa_pkg::ST_ARMED)
                        || (st_r == cfa_pkg::ST_RUN);
   assign trig_armed = (st_r == cfa_pkg::ST_ARMED);
   assign acq_done = done_r;
   assign stream_overflow_flag = ovf_r;
   // two bytes of memory per sample
   assign mem_fill_bytes = {mcnt_r, 1'b0};

   AST_MODE_RB: assert property (@(posedge clk_sys) disable iff (srst)
      reg_wr && reg_addr == cfa_pkg::IDX_MODE ##1 !reg_wr
      |=> reg_rdata[31:0] == $past(reg_wdata[31:0], 2)
          || $past(reg_addr) != cfa_pkg::IDX_MODE)
      else $error("mode read-back differs from written code");
   AST_START_MODE: assert property (@(posedge clk_sys) disable iff (srst)
      st_r == cfa_pkg::ST_IDLE && mode_r != cfa_pkg::MODE_STREAM
      |=> st_r == cfa_pkg::ST_IDLE)
      else $error("started outside streaming mode");
   AST_FILL_DISARMED: assert property (@(posedge clk_sys) disable iff (srst)
      st_r == cfa_pkg::ST_FILL |=> st_r != cfa_pkg::ST_RUN
      && (st_r != cfa_pkg::ST_ARMED || $past(pre_cnt) >= $past(pre_eff)))
      else $error("trigger taken during pre-event fill");
   AST_ARMED_FULL: assert property (@(posedge clk_sys) disable iff (srst)
      st_r == cfa_pkg::ST_ARMED && $past(st_r) == cfa_pkg::ST_FILL
      && $stable(pre_r) |-> pre_cnt == pre_eff)
      else $error("armed with pre-event area not full");
   AST_LAST_SEG: assert property (@(posedge clk_sys) disable iff (srst)
      st_r == cfa_pkg::ST_RUN ##1 st_r == cfa_pkg::ST_DONE
      |-> seg_r == $past(loops_r) && $past(loops_r) != '0)
      else $error("finished at wrong segment count");
   AST_ENDLESS: assert property (@(posedge clk_sys) disable iff (srst)
      st_r == cfa_pkg::ST_RUN && loops_r == '0 && !cmd_stop
      |=> st_r == cfa_pkg::ST_RUN)
      else $error("endless capture ended without stop");
   AST_OVERFLOW: assert property (@(posedge clk_sys) disable iff (srst)
      st_r == cfa_pkg::ST_RUN && fwd && !room
      |=> stream_overflow_flag
      ##1 (stream_overflow_flag || st_r == cfa_pkg::ST_FILL))
      else $error("overflow not flagged");
   AST_DONE_QUIET: assert property (@(posedge clk_sys) disable iff (srst)
      st_r == cfa_pkg::ST_DONE |-> !mem_we && acq_done)
      else $error("sample written after completion");
endmodule

// *** cfa_host_sink.sv ***
// cfa_host_sink: host memory end of the transfer, takes words under ready
// assumes dma_valid/dma_data keep to valid/ready on clk_sys
`timescale 1ns/10ps
module cfa_host_sink (
   input wire logic clk_sys, // system clock
   input wire logic srst, // synchronous reset
   input wire logic hold, // bench stalls the host
   input wire logic dma_valid, // word offered
   input wire logic [15:0] dma_data, // word offered
   output logic dma_ready, // host accepts word
   output logic got, // word taken at last edge
   output logic [15:0] got_data // word taken
);
   logic [7:0] lfsr_r;
   // slow host: ready follows a pseudo-random pattern, stays low while stalled
   always @(posedge clk_sys)
   begin
      lfsr_r <= srst ? 8'hA5 : {lfsr_r[6:0],
         lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      dma_ready <= !srst && !hold && lfsr_r[0];
      got <= !srst && dma_valid && dma_ready;
      got_data <= dma_data;
   end
endmodule

// *** cfa_stream_acq_bench.sv ***
// cfa_stream_acq_bench: self-checking bench for the streaming sequencer
// assumes cfa_pkg, cfa_strm_if, the design and the host sink compiled first
`timescale 1ns/10ps
module cfa_stream_acq_bench;
   logic clk_sys, srst, reg_wr, cmd_start, cmd_stop, trig_in;
   logic adc_valid, dma_valid, dma_ready, acq_running, trig_armed;
   logic acq_done, stream_overflow_flag, hold, got;
   logic [15:0] reg_addr, adc_data, dma_data, got_data, cur;
   logic [63:0] reg_wdata, reg_rdata;
   logic [1:0] chan_sel;
   logic [11:0] mem_fill_bytes;
   logic [31:0] seed;
   logic [15:0] hist[$];
   logic [15:0] exp_q[$];
   int miscompares, check_count, n_got;
   bit chk_data, armed;

   cfa_stream_acq u_dut (
      .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .cmd_start(cmd_start), .cmd_stop(cmd_stop), .trig_in(trig_in),
      .chan_sel(chan_sel), .adc_valid(adc_valid), .adc_data(adc_data),
      .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_data(dma_data),
      .acq_running(acq_running), .trig_armed(trig_armed),
      .acq_done(acq_done), .stream_overflow_flag(stream_overflow_flag),
      .mem_fill_bytes(mem_fill_bytes)
   );

   cfa_host_sink u_host (
      .clk_sys(clk_sys), .srst(srst), .hold(hold), .dma_valid(dma_valid),
      .dma_data(dma_data), .dma_ready(dma_ready), .got(got),
      .got_data(got_data)
   );

   // 25 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic finish_test;
      if (miscompares == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // register write: one strobe cycle
   task automatic wr(input logic [15:0] a, input logic [63:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // register read: data one edge after the index is sampled
   task automatic rd(input logic [15:0] a, input logic [63:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      repeat (2) @(posedge clk_sys);
      #1;
      check("register read", reg_rdata, exp);
   endtask

   // one-cycle start or stop command
   task automatic pulse(input bit stop);
      @(posedge clk_sys);
      if (stop)
         cmd_stop <= 1'b1;
      else
         cmd_start <= 1'b1;
      @(posedge clk_sys);
      cmd_start <= 1'b0;
      cmd_stop <= 1'b0;
   endtask

   // one random sample; armed tells the state that will sample it
   task automatic step(input logic t);
      @(posedge clk_sys);
      seed = xs(seed);
      cur = seed[15:0];
      adc_valid <= 1'b1;
      adc_data <= cur;
      trig_in <= t;
      @(negedge clk_sys);
      armed = trig_armed;
   endtask

   task automatic idle;
      @(posedge clk_sys);
      adc_valid <= 1'b0;
      trig_in <= 1'b0;
   endtask

   // reference stream: every word taken by the host while chk_data is set, against the model
   always @(posedge clk_sys)
   begin
      if (got)
      begin
         n_got++;
         if (chk_data && exp_q.size() > 0)
            check("host word", got_data, exp_q.pop_front());
         else if (chk_data)
            check("surplus host word", got_data, 64'h10000);
      end
   end

   // hang guard
   initial
   begin
      #(40 * 5000);
      miscompares++;
      finish_test();
   end

   initial
   begin
      srst = 1'b1;
      reg_addr = 16'h0;
      reg_wr = 1'b0;
      reg_wdata = 64'h0;
      cmd_start = 1'b0;
      cmd_stop = 1'b0;
      trig_in = 1'b0;
      chan_sel = 2'h0;
      adc_valid = 1'b0;
      adc_data = 16'h0;
      hold = 1'b0;
      seed = 32'h0000_C8A1;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      rd(cfa_pkg::IDX_MODE, {32'h0, cfa_pkg::RST_MODE});
      rd(cfa_pkg::IDX_SEGLEN, cfa_pkg::RST_SEGLEN);
      rd(cfa_pkg::IDX_LOOPS, cfa_pkg::RST_LOOPS);
      rd(cfa_pkg::IDX_PRE, cfa_pkg::RST_PRE);
      rd(16'h1234, 64'h0);
      // start refused outside streaming mode
      pulse(1'b0);
      repeat (2) @(negedge clk_sys);
      check("start in other mode", acq_running, 64'h0);
      // two segments of eight with four samples ahead of the trigger
      wr(cfa_pkg::IDX_MODE, {32'h0, cfa_pkg::MODE_STREAM});
      rd(cfa_pkg::IDX_MODE, {32'h0, cfa_pkg::MODE_STREAM});
      wr(cfa_pkg::IDX_SEGLEN, 64'h8);
      wr(cfa_pkg::IDX_LOOPS, 64'h2);
      wr(cfa_pkg::IDX_PRE, 64'h4);
      rd(cfa_pkg::IDX_SEGLEN, 64'h8);
      rd(cfa_pkg::IDX_LOOPS, 64'h2);
      rd(cfa_pkg::IDX_PRE, 64'h4);
      chk_data = 1'b1;
      pulse(1'b0);
      do
      begin
         step(1'b1);
         if (!armed)
            hist.push_back(cur);
      end
      while (!armed && hist.size() < 40);
      check("samples before arming", hist.size() >= 4, 64'h1);
      for (int i = 4; i > 0; i--)
         exp_q.push_back(hist[hist.size() - i]);
      exp_q.push_back(cur);
      repeat (11)
      begin
         step(1'b0);
         exp_q.push_back(cur);
      end
      check("draining during capture", n_got > 0, 64'h1);
      repeat (12) step(1'b0);
      idle();
      for (int i = 0; i < 400 && n_got < 16; i++)
         @(posedge clk_sys);
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys);
      check("words in run", n_got, 64'h10);
      check("done flag", acq_done, 64'h1);
      check("running after done", acq_running, 64'h0);
      check("overflow in clean run", stream_overflow_flag, 64'h0);
      check("memory bytes after run", mem_fill_bytes, 64'h0);
      // endless run, four channels, host stalled through memory overflow until after the stop
      chk_data = 1'b0;
      @(posedge clk_sys);
      hold <= 1'b1;
      chan_sel <= 2'h2;
      wr(cfa_pkg::IDX_LOOPS, 64'h0);
      wr(cfa_pkg::IDX_PRE, 64'h0);
      pulse(1'b0);
      repeat (300) step(1'b1);
      idle();
      @(negedge clk_sys);
      check("overflow flag", stream_overflow_flag, 64'h1);
      check("memory limit bytes", mem_fill_bytes, 64'h200);
      check("endless run", acq_running, 64'h1);
      check("done cleared", acq_done, 64'h0);
      pulse(1'b1);
      @(negedge clk_sys);
      check("stopped", acq_running, 64'h0);
      @(posedge clk_sys);
      hold <= 1'b0;
      for (int i = 0; i < 2000 && mem_fill_bytes != 12'h0; i++)
         @(posedge clk_sys);
      @(negedge clk_sys);
      check("memory drained", mem_fill_bytes, 64'h0);
      finish_test();
   end
endmodule
